// *** rtl/polyphase_current_derive_accum.sv ***
/*
  current derivation, instant power, interval timing and averaging,
  with a sample fifo ahead of the divider.
  assumes strobe, samples and host strobes all share mclk.
*/
`include "polyphase_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// sample fifo
// ------------------------------------------------------------
module sample_fifo #(
  parameter int W = 73,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];   // storage words
  logic [AW-1:0] wr_ptr;   // next write slot
  logic [AW-1:0] rd_ptr;   // next read slot
  logic [AW:0]   count;    // words held
  logic push;
  logic pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != D[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : sample_fifo

// ------------------------------------------------------------
// top block
// ------------------------------------------------------------
module polyphase_current_derive_accum (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // high-rate sample stream
  input  wire logic                 sample_stb,
  input  wire polyphase_pkg::s23_t  ai1,
  input  wire polyphase_pkg::s23_t  ai2,
  input  wire polyphase_pkg::s23_t  ai3,
  input  wire polyphase_pkg::s23_t  va,
  input  wire polyphase_pkg::s23_t  vb,
  input  wire polyphase_pkg::s23_t  vc,
  output logic                      sample_ready,
  // line lock control
  input  wire logic                 line_lock_en,
  input  wire logic                 ac_valid,
  // host writes
  input  wire polyphase_pkg::word_t wr_data,
  input  wire logic                 cfg_wr,
  input  wire logic                 samples_wr,
  input  wire logic                 ifs_wr,
  input  wire logic                 vfs_wr,
  input  wire logic                 ready_clr,
  input  wire logic [2:0]           alarm_sel,
  // host readback
  output polyphase_pkg::word_t      input_config_word,
  output polyphase_pkg::word_t      samples_cfg,
  output polyphase_pkg::word_t      sample_cycle_counter,
  output polyphase_pkg::word_t      interval_count,
  output polyphase_pkg::word_t      last_interval_length,
  output polyphase_pkg::word_t      current_fullscale_scratch,
  output polyphase_pkg::word_t      voltage_fullscale_scratch,
  output logic                      data_ready,
  // gain-8 pre-amp enables
  output logic                      gain8_phase_a,
  output logic                      gain8_phase_b,
  output logic                      gain8_phase_c,
  // instantaneous results
  output polyphase_pkg::s23_t       inst_ia,
  output polyphase_pkg::s23_t       inst_ib,
  output polyphase_pkg::s23_t       inst_ic,
  output polyphase_pkg::s23_t       inst_pa,
  output polyphase_pkg::s23_t       inst_pb,
  output polyphase_pkg::s23_t       inst_pc,
  // low-rate averaged currents
  output polyphase_pkg::s23_t       avg_ia,
  output polyphase_pkg::s23_t       avg_ib,
  output polyphase_pkg::s23_t       avg_ic,
  // alarm pins
  output logic [4:0]                alarm_out
);
  import polyphase_pkg::*;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // clamp a wide value into the s.23 range
  function automatic s23_t sat24(input logic signed [49:0] x);
    if (x > 50'sh7fffff) begin
      sat24 = 24'sh7fffff;
    end else if (x < -50'sh800000) begin
      sat24 = 24'sh800000;
    end else begin
      sat24 = x[23:0];
    end
  endfunction : sat24

  // fractional product, fullscale times fullscale is fullscale
  function automatic s23_t mul_s23(input s23_t a, input s23_t b);
    logic signed [47:0] p;
    p = a * b;
    mul_s23 = sat24(50'(p >>> 23));
  endfunction : mul_s23

  // ------------------------------------------------------------
  // current derivation
  // ------------------------------------------------------------
  logic [1:0] miss;        // missing phase field
  logic       neutral;     // neutral sensor fitted
  logic       delta;       // delta connection
  logic signed [49:0] w1;  // widened inputs
  logic signed [49:0] w2;
  logic signed [49:0] w3;
  s23_t next_ia;
  s23_t next_ib;
  s23_t next_ic;

  assign miss    = input_config_word[`CFG_MISS_HI:`CFG_MISS_LO]; // RULE_23
  assign neutral = input_config_word[`CFG_NEUTRAL];              // RULE_23
  assign delta   = input_config_word[`CFG_DELTA];                // RULE_25
  assign w1      = 50'(ai1);
  assign w2      = 50'(ai2);
  assign w3      = 50'(ai3);

  // phase equations; neutral with phase 00 is left to the host
  always_comb begin
    next_ia = ai1;
    next_ib = ai2;
    next_ic = ai3;
    case (miss)
      `MISS_A: begin
        next_ia = neutral ? sat24(w1 - (w2 + w3))          // RULE_02
                : delta ? sat24(w2 - w3) : sat24(-(w2 + w3)); // RULE_25
      end
      `MISS_B: begin
        next_ib = neutral ? sat24(w2 - (w3 + w1))          // RULE_03
                : delta ? sat24(w3 - w1) : sat24(-(w3 + w1)); // RULE_25
      end
      `MISS_C: begin
        next_ic = neutral ? sat24(w3 - (w1 + w2))          // RULE_04
                : delta ? sat24(w1 - w2) : sat24(-(w1 + w2)); // RULE_01
      end
      default: begin
        next_ia = ai1;   // three sensors, straight through
      end
    endcase
  end

  // ------------------------------------------------------------
  // host registers
  // ------------------------------------------------------------
  // configuration, interval length and scratch words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_config_word         <= `CFG_RESET;
      samples_cfg               <= `SAMPLES_RESET;   // RULE_12
      current_fullscale_scratch <= '0;
      voltage_fullscale_scratch <= '0;
    end else begin
      if (cfg_wr) begin
        input_config_word <= wr_data;
      end
      if (samples_wr) begin
        samples_cfg <= wr_data;
      end
      // stored only, never read by the datapath
      if (ifs_wr) begin
        current_fullscale_scratch <= wr_data;  // RULE_22
      end
      if (vfs_wr) begin
        voltage_fullscale_scratch <= wr_data;  // RULE_22
      end
    end
  end

  // pre-amp enables follow their config bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain8_phase_a <= 1'b0;
      gain8_phase_b <= 1'b0;
      gain8_phase_c <= 1'b0;
    end else begin
      gain8_phase_a <= input_config_word[`CFG_GAIN8_A];  // RULE_05
      gain8_phase_b <= input_config_word[`CFG_GAIN8_B];  // RULE_05
      gain8_phase_c <= input_config_word[`CFG_GAIN8_C];  // RULE_05
    end
  end

  // ------------------------------------------------------------
  // instantaneous results
  // ------------------------------------------------------------
  // refreshed once per strobe, held in between
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inst_ia <= '0;
      inst_ib <= '0;
      inst_ic <= '0;
      inst_pa <= '0;
      inst_pb <= '0;
      inst_pc <= '0;
    end else if (sample_stb) begin
      inst_ia <= next_ia;               // RULE_06
      inst_ib <= next_ib;               // RULE_06
      inst_ic <= next_ic;               // RULE_06
      inst_pa <= mul_s23(va, next_ia);  // RULE_18
      inst_pb <= mul_s23(vb, next_ib);  // RULE_18
      inst_pc <= mul_s23(vc, next_ic);  // RULE_18
    end
  end

  // ------------------------------------------------------------
  // interval timing
  // ------------------------------------------------------------
  logic signed [25:0] vzc;       // composite crossing signal
  logic               vzc_neg;   // previous composite was negative
  logic               pos_cross; // negative to non-negative
  word_t              run_len;   // samples in current interval
  word_t              len_now;   // count including this sample
  logic               reached;   // programmed count met
  logic               int_end;   // this sample closes the interval
  logic               results_done;

  assign vzc = 26'(va) - 26'(vb >>> 1) - 26'(vc >>> 2);  // RULE_16
  assign pos_cross = vzc_neg && !vzc[25];
  assign len_now   = run_len + 24'h000001;
  assign reached   = (len_now >= samples_cfg);

  // interval end, only ever with the strobe
  always_comb begin
    int_end = 1'b0;
    if (sample_stb && reached) begin
      if (!line_lock_en) begin
        int_end = 1'b1;                                  // RULE_12
      end else if (ac_valid) begin
        int_end = pos_cross;                             // RULE_13
      end else begin
        int_end = (len_now >= samples_cfg + `TIMEOUT_SAMPLES); // RULE_14
      end
    end
  end

  // crossing history, sampled with the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vzc_neg <= 1'b0;
    end else if (sample_stb) begin
      vzc_neg <= vzc[25];  // RULE_26
    end
  end

  // interval length, frame counter and recorded length
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_len              <= '0;
      interval_count       <= '0;
      last_interval_length <= '0;
    end else if (int_end) begin
      run_len              <= '0;
      interval_count       <= interval_count + 24'h000001;  // RULE_08
      last_interval_length <= len_now;                      // RULE_15
    end else if (sample_stb) begin
      run_len <= len_now;  // RULE_26
    end
  end

  // cycle counter, cleared when the averages land
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_cycle_counter <= '0;
    end else if (results_done) begin
      sample_cycle_counter <= sample_stb ? 24'h000001 : '0;  // RULE_07
    end else if (sample_stb) begin
      sample_cycle_counter <= sample_cycle_counter + 24'h000001;  // RULE_07
    end
  end

  // ------------------------------------------------------------
  // sample fifo toward the averager
  // ------------------------------------------------------------
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [72:0] fifo_out_data;

  // end-of-interval mark travels with its sample
  sample_fifo #(.W(73), .D(8)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (sample_stb),
    .in_ready  (fifo_in_ready),
    .in_data   ({int_end, next_ic, next_ib, next_ia}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // back-pressure seen by the front end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= fifo_in_ready;
    end
  end

  // ------------------------------------------------------------
  // accumulate and average
  // ------------------------------------------------------------
  avg_state_t         state;
  logic signed [47:0] acc [3];  // per-phase sums
  word_t              acc_n;    // samples summed
  logic [1:0]         ch;       // channel being divided
  logic [47:0]        dvd;      // dividend magnitude, shifting
  logic [47:0]        quo;      // quotient bits
  logic [24:0]        rem;      // partial remainder
  logic [5:0]         step;     // divide steps left
  logic               neg;      // result sign
  logic [24:0]        rem_sh;
  logic               pop;

  // the divider stalls draining, so the fifo can really fill
  assign fifo_out_ready = (state == AVG_IDLE);
  assign pop            = fifo_out_valid && fifo_out_ready;
  assign rem_sh         = {rem[23:0], dvd[47]};

  // sums, sequencer and restoring divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= AVG_IDLE;
      acc          <= '{default: '0};
      acc_n        <= '0;
      ch           <= '0;
      dvd          <= '0;
      quo          <= '0;
      rem          <= '0;
      step         <= '0;
      neg          <= 1'b0;
      avg_ia       <= '0;
      avg_ib       <= '0;
      avg_ic       <= '0;
      results_done <= 1'b0;
    end else begin
      results_done <= 1'b0;
      case (state)
        AVG_IDLE: begin
          if (pop) begin
            for (int k = 0; k < 3; k++) begin
              acc[k] <= acc[k] + 48'(signed'(fifo_out_data[k*24 +: 24])); // RULE_11
            end
            acc_n <= acc_n + 24'h000001;
            if (fifo_out_data[72]) begin
              ch    <= '0;
              state <= AVG_LOAD;
            end
          end
        end
        AVG_LOAD: begin
          // take the magnitude, restore the sign at the end
          neg   <= acc[ch][47];
          dvd   <= acc[ch][47] ? 48'(-acc[ch]) : acc[ch];
          quo   <= '0;
          rem   <= '0;
          step  <= `DIV_STEPS;
          state <= AVG_DIV;
        end
        AVG_DIV: begin
          dvd  <= {dvd[46:0], 1'b0};
          step <= step - 6'h01;
          if (rem_sh >= {1'b0, acc_n}) begin
            rem <= rem_sh - {1'b0, acc_n};
            quo <= {quo[46:0], 1'b1};
          end else begin
            rem <= rem_sh;
            quo <= {quo[46:0], 1'b0};
          end
          if (step == 6'h01) begin
            // last bit goes in through avg_value
            case (ch)
              2'h0:    avg_ia <= avg_value(neg, quo, rem_sh >= {1'b0, acc_n}); // RULE_11
              2'h1:    avg_ib <= avg_value(neg, quo, rem_sh >= {1'b0, acc_n}); // RULE_11
              default: avg_ic <= avg_value(neg, quo, rem_sh >= {1'b0, acc_n}); // RULE_11
            endcase
            if (ch == 2'h2) begin
              acc          <= '{default: '0};
              acc_n        <= '0;
              results_done <= 1'b1;
              state        <= AVG_IDLE;
            end else begin
              ch    <= ch + 2'h1;
              state <= AVG_LOAD;
            end
          end
        end
        default: begin
          state <= AVG_IDLE;
        end
      endcase
    end
  end

  // final quotient with the last bit, signed and clamped
  function automatic s23_t avg_value(input logic n, input logic [47:0] q,
                                     input logic b);
    logic signed [49:0] mag;
    mag = 50'({q[46:0], b});
    avg_value = n ? sat24(-mag) : sat24(mag);
  endfunction : avg_value

  // ------------------------------------------------------------
  // data ready flag and alarm routing
  // ------------------------------------------------------------
  // a set beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_ready <= 1'b0;
    end else if (results_done) begin
      data_ready <= 1'b1;  // RULE_09
    end else if (ready_clr) begin
      data_ready <= 1'b0;
    end
  end

  // select 1..5 drives one pin, others leave all low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_out <= '0;
    end else begin
      for (int p = 0; p < `ALARM_PINS; p++) begin
        alarm_out[p] <= data_ready && (alarm_sel == 3'(p + 1));  // RULE_10
      end
    end
  end
endmodule : polyphase_current_derive_accum

`default_nettype wire

// *** rtl/polyphase_consts.svh ***
/*
  config field positions, reset values and interval counts.
  assumes inclusion by bare name.
*/
// Operation
// RULE_01: no neutral, C missing: sum or difference form
// RULE_02: neutral on input one gives A
// RULE_03: neutral on input two gives B
// RULE_04: neutral on input three gives C
// RULE_05: gain-8 enables at config bits 9,11,13
// RULE_06: instantaneous results refresh every sample
// RULE_07: 24-bit sample counter, cleared on results
// RULE_08: interval counter increments each interval end
// RULE_09: data-ready flag set on new results
// RULE_10: data-ready routable to one of five alarms
// RULE_11: results average all samples of interval
// RULE_12: no line lock: programmed count, default 540
// RULE_13: line lock with AC: next positive crossing
// RULE_14: line lock without AC: count plus 100
// RULE_15: record last interval length in samples
// RULE_16: crossings from VA - VB/2 - VC/4
// RULE_17: voltage/current/power are S.23 fractions
// RULE_18: power is current times voltage fullscale
// RULE_19: power factor in S.22
// RULE_20: frequency in S.16
// RULE_21: temperature in S.10
// RULE_22: scratch fullscale words writable, otherwise unused
// RULE_23: neutral at bit 2, missing phase 1:0
// RULE_24: host never sets neutral with phase 00
// RULE_25: delta flag bit 5 selects difference form
// RULE_26: counting advances only on sample strobe
`ifndef POLYPHASE_CONSTS_SVH
`define POLYPHASE_CONSTS_SVH

// ------------------------------------------------------------
// configuration word fields
// ------------------------------------------------------------
`define CFG_MISS_LO     0
`define CFG_MISS_HI     1
`define CFG_NEUTRAL     2
`define CFG_DELTA       5
`define CFG_GAIN8_C     9
`define CFG_GAIN8_B     11
`define CFG_GAIN8_A     13
`define MISS_NONE       2'h0
`define MISS_A          2'h1
`define MISS_B          2'h2
`define MISS_C          2'h3

// ------------------------------------------------------------
// reset values and interval counts
// ------------------------------------------------------------
`define CFG_RESET       24'h000000
`define SAMPLES_RESET   24'h00021c
`define TIMEOUT_SAMPLES 24'h000064
`define DIV_STEPS       6'h30
`define ALARM_PINS      5

`endif

// *** rtl/polyphase_pkg.sv ***
/*
  result formats and averaging sequencer states.
  assumes nothing of its surroundings.
*/
package polyphase_pkg;
  // ------------------------------------------------------------
  // result formats
  // ------------------------------------------------------------
  typedef logic signed [23:0] s23_t;   // voltage, current, power  RULE_17
  typedef logic signed [23:0] s22_t;   // power factor, -2..2  RULE_19
  typedef logic signed [23:0] s16_t;   // frequency, -128..128 Hz  RULE_20
  typedef logic signed [23:0] s10_t;   // temperature  RULE_21
  typedef logic [23:0]        word_t;  // plain register word

  // ------------------------------------------------------------
  // averaging sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    AVG_IDLE,
    AVG_LOAD,
    AVG_DIV
  } avg_state_t;
endpackage : polyphase_pkg

// *** bench/polyphase_properties.sv ***
/* port checker for the polyphase block, bound from the bench top.
   assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
// ------------
// port checker
// ------------
module polyphase_properties (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // causes
  input wire logic                 sample_stb,
  input wire logic                 cfg_wr,
  input wire polyphase_pkg::word_t wr_data,
  input wire logic                 line_lock_en,
  input wire logic                 ac_valid,
  input wire logic [2:0]           alarm_sel,
  // effects
  input wire polyphase_pkg::word_t samples_cfg,
  input wire polyphase_pkg::word_t sample_cycle_counter,
  input wire polyphase_pkg::word_t interval_count,
  input wire polyphase_pkg::word_t last_interval_length,
  input wire logic                 data_ready,
  input wire logic                 gain8_phase_a,
  input wire logic                 gain8_phase_c,
  input wire logic [4:0]           alarm_out
);
  import polyphase_pkg::*;
  // one clock domain
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  AST_GAIN_A: assert property (cfg_wr |-> ##2 gain8_phase_a == $past(wr_data[13], 2))
    else $error("gain a wrong");
  AST_GAIN_C: assert property (cfg_wr |-> ##2 gain8_phase_c == $past(wr_data[9], 2))
    else $error("gain c wrong");
  // ready high may hide a clear: skipped
  AST_CYC_INC: assert property (sample_stb ##1 !data_ready
    |-> sample_cycle_counter == $past(sample_cycle_counter) + 24'h1) else $error("no count");
  AST_CYC_HOLD: assert property (!sample_stb ##1 !data_ready
    |-> $stable(sample_cycle_counter)) else $error("count moved");
  AST_RDY_CLR: assert property ($rose(data_ready) |-> sample_cycle_counter <= 24'h1)
    else $error("count not cleared");
  AST_FRAME: assert property ($changed(interval_count) |-> $past(sample_stb)
    && interval_count == $past(interval_count) + 24'h1) else $error("frame step");
  AST_LEN_FIX: assert property ($changed(interval_count) && !$past(line_lock_en)
    |-> last_interval_length == samples_cfg) else $error("fixed length");
  AST_LEN_TO: assert property ($changed(interval_count) && $past(line_lock_en)
    && !$past(ac_valid) |-> last_interval_length == samples_cfg + 24'h64)
    else $error("timeout length");
  AST_ALARM: assert property (data_ready && alarm_sel == 3'h2 |=> alarm_out[1])
    else $error("alarm route");
endmodule : polyphase_properties
`default_nettype wire

// *** bench/host_model.sv ***
/* host partner: one-cycle register write strobes, alarm routing.
   assumes the block's mclk. */
`timescale 1ns/1ps
`default_nettype none
// ----------
// host model
// ----------
module host_model (
  // clock
  input  wire logic          mclk,
  // write side
  output polyphase_pkg::word_t wr_data,
  output logic [4:0]         wr_sel,
  output logic [2:0]         alarm_sel
);
  import polyphase_pkg::*;
  initial begin
    wr_data = 24'h0;
    wr_sel = 5'h00;
    alarm_sel = 3'h0;
  end
  // strobe bit s: 0 config, 1 count, 2/3 scratch, 4 ready clear
  task automatic wr(input int s, input word_t d);
    if (s == 0 && d[1:0] == 2'h0) d[2] = 1'b0;
    wr_data <= d;
    wr_sel <= 5'h01 << s;
    @(posedge mclk);
    wr_sel <= 5'h00;
    wr_data <= ~d; // no stale word when idle
    @(posedge mclk);
  endtask : wr
  task automatic alarm(input logic [2:0] a);
    alarm_sel <= a;
  endtask : alarm
endmodule : host_model
`default_nettype wire

// *** bench/test_polyphase_current_derive_accum.sv ***
/* bench top: block, host model, scenario tasks, bound checker.
   assumes a 20 MHz mclk and held-off reset for 12 cycles. */
`timescale 1ns/1ps
`default_nettype none
// ---------
// bench top
// ---------
module test_polyphase_current_derive_accum;
  import polyphase_pkg::*;
  logic       mclk = 1'b0, rst_n = 1'b0, sample_stb = 1'b0, line_lock_en = 1'b0;
  logic       ac_valid = 1'b0, srdy, drdy, ga, gb, gc, full_seen;
  s23_t       ai1 = 24'sh100, ai2 = 24'sh30, ai3 = 24'sh7, vb = '0, va = 24'sh100000; // samples
  word_t      wd, cfgw, scfg, cyc, icnt, ilen, ifs, vfs;
  s23_t       ia, ib, ic, aia, aib, aic, pa;
  logic [4:0] hs, alm;
  logic [2:0] asel;
  int         checked = 0, bad_count = 0, cyc_n = 0;
  polyphase_current_derive_accum dut (.mclk(mclk), .rst_n(rst_n), .sample_stb(sample_stb),
    .ai1(ai1), .ai2(ai2), .ai3(ai3), .va(va), .vb(vb), .vc(va), .sample_ready(srdy),
    .line_lock_en(line_lock_en), .ac_valid(ac_valid), .wr_data(wd), .cfg_wr(hs[0]),
    .samples_wr(hs[1]), .ifs_wr(hs[2]), .vfs_wr(hs[3]), .ready_clr(hs[4]), .alarm_sel(asel),
    .input_config_word(cfgw), .samples_cfg(scfg), .sample_cycle_counter(cyc),
    .interval_count(icnt), .last_interval_length(ilen), .current_fullscale_scratch(ifs),
    .voltage_fullscale_scratch(vfs), .data_ready(drdy), .gain8_phase_a(ga),
    .gain8_phase_b(gb), .gain8_phase_c(gc), .inst_ia(ia), .inst_ib(ib), .inst_ic(ic),
    .inst_pa(pa), .inst_pb(), .inst_pc(), .avg_ia(aia), .avg_ib(aib), .avg_ic(aic),
    .alarm_out(alm));
  host_model host (.mclk(mclk), .wr_data(wd), .wr_sel(hs), .alarm_sel(asel));
  always #25 mclk = ~mclk; // 50 ns period
  // hang guard
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one strobe, then a gap
  task automatic stb(input int gap);
    sample_stb <= 1'b1;
    @(posedge mclk);
    sample_stb <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask : stb
  task automatic t_regs;
    chk("count reset", scfg, 24'h00021c);
    host.wr(1, 24'h5);
    host.wr(2, 24'h5a5a5a);
    host.wr(3, 24'ha5a5a5);
    chk("i scratch", ifs, 24'h5a5a5a);
    chk("v scratch", vfs, 24'ha5a5a5);
  endtask : t_regs
  // each missing-phase mode, ends the first 5-sample interval
  task automatic t_derive;
    word_t cf[5];
    s23_t  ex[5];
    cf = '{24'h3, 24'h23, 24'h2a05, 24'h6, 24'h7};
    ex = '{-(ai1 + ai2), ai1 - ai2, ai1 - (ai2 + ai3), ai2 - (ai3 + ai1), ai3 - (ai1 + ai2)};
    for (int i = 0; i < 5; i++) begin
      host.wr(0, cf[i]);
      stb(200);
      chk("derived", (i == 2) ? ia : (i == 3) ? ib : ic, ex[i]);
      chk("gain8", {21'h0, ga, gb, gc}, (i == 2) ? 24'h7 : 24'h0);
      chk("config", cfgw, cf[i]);
    end
  endtask : t_derive
  // one interval; vb makes a rising crossing at sample 6
  task automatic run_int(input int len);
    word_t f;
    int    n;
    f = icnt;
    n = 0;
    while (icnt === f && n < 200) begin
      n++;
      vb <= ((n >> 1) & 1) ? -24'sh400000 : 24'sh400000;
      stb(200);
    end
    chk("length", ilen, len);
    chk("frame", icnt, f + 24'h1);
    chk("ready", {23'h0, drdy}, 24'h1);
    chk("cycle", cyc, 24'h0);
    chk("average", aia, ai1);
    chk("avg b", aib, ai2);
    chk("avg c", aic, ai3);
    chk("power", pa, ai1 >>> 3);
  endtask : run_int
  task automatic clr;
    host.wr(4, 24'h0);
    chk("cleared", {23'h0, drdy}, 24'h0);
  endtask : clr
  // all route codes, ready held high
  task automatic t_alarm;
    for (int s = 0; s < 8; s++) begin
      host.alarm(s[2:0]);
      repeat (2) @(posedge mclk);
      chk("alarm", {19'h0, alm}, (s > 0 && s < 6) ? 24'h1 << (s - 1) : 24'h0);
    end
    host.alarm(3'h2);
  endtask : t_alarm
  // strobes every other cycle
  task automatic t_fifo;
    full_seen = 1'b0;
    for (int i = 0; i < 40; i++) begin
      stb(1);
      if (srdy === 1'b0) full_seen = 1'b1;
    end
    chk("fifo full", {23'h0, full_seen}, 24'h1);
    repeat (3000) @(posedge mclk);
    chk("fifo drained", {23'h0, srdy}, 24'h1);
  endtask : t_fifo
  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    host.alarm(3'h2);
    t_derive();
    clr();
    host.wr(0, 24'h0);
    run_int(5);
    clr();
    line_lock_en <= 1'b1;
    run_int(105);
    clr();
    ac_valid <= 1'b1;
    run_int(6);
    t_alarm();
    clr();
    line_lock_en <= 1'b0;
    t_fifo();
    results();
  end
endmodule : test_polyphase_current_derive_accum
bind polyphase_current_derive_accum polyphase_properties chk_i (.mclk(mclk), .rst_n(rst_n),
  .sample_stb(sample_stb), .cfg_wr(cfg_wr), .wr_data(wr_data), .line_lock_en(line_lock_en),
  .ac_valid(ac_valid), .alarm_sel(alarm_sel), .samples_cfg(samples_cfg),
  .sample_cycle_counter(sample_cycle_counter), .interval_count(interval_count),
  .last_interval_length(last_interval_length), .data_ready(data_ready),
  .gain8_phase_a(gain8_phase_a), .gain8_phase_c(gain8_phase_c), .alarm_out(alarm_out));
`default_nettype wire
